// >>> design/spics_pkg.sv
// Purpose: shared constants and types of the serial peripheral control and status block
// Assumes: 32-bit APB, registers one aligned word each, byte address = index * 4
// Notes: status layout matches spics_stat_s bit for bit
package spics_pkg;
  // register indices; byte address is index * 4
  localparam logic [9:0] SPICS_IDX_STATUS = 10'h0BD;
  localparam logic [9:0] SPICS_IDX_DATA = 10'h0BE;
  localparam logic [9:0] SPICS_IDX_MASK = 10'h0BF;
  localparam logic [9:0] SPICS_IDX_IST = 10'h0C0;
  // status field positions
  localparam int SPICS_BIT_DONE = 7;
  localparam int SPICS_BIT_WRITE_COLLISION_FLAG = 6;
  localparam int SPICS_BIT_MODF = 5;
  localparam int SPICS_BIT_BUSY = 4;
  localparam int SPICS_BIT_SELECT_PIN_DISABLE = 3;
  localparam int SPICS_BIT_BIT_ORDER_SELECT = 2;
  localparam int SPICS_BIT_RATE = 0;
  // interrupt status / mask field positions
  localparam int SPICS_IRQ_DONE = 0;
  localparam int SPICS_IRQ_WRITE_COLLISION_FLAG = 1;
  localparam int SPICS_IRQ_MODF = 2;
  // reset values
  localparam logic [7:0] SPICS_STATUS_RST = 8'h00;
  localparam logic [2:0] SPICS_MASK_RST = 3'h0;
  localparam logic [2:0] SPICS_IST_RST = 3'h0;
  localparam logic [7:0] SPICS_DATA_RST = 8'h00;
  // bits per byte transfer, last bit index
  localparam logic [2:0] SPICS_LAST_BIT = 3'h7;

  typedef struct packed {
    logic done;
    logic write_collision_flag;
    logic modf;
    logic busy;
    logic select_pin_disable;
    logic bit_order_select;
    logic [1:0] rate;
  } spics_stat_s;

  typedef enum logic [0:0] {
    SPICS_IDLE = 1'b0,
    SPICS_RUN = 1'b1
  } spics_state_e;
endpackage

// >>> design/spics_top.sv
// Purpose: serial peripheral control/status: bit order, clock rate, flags, byte shifter
// Assumes: single clock pclk at 125 MHz; miso and ss_n come from pins
// Notes: the block runs as bus master of the serial link, mode 0 clocking
//
// How it works
// RL1: bit order field selects MSB or LSB first
// RL2: rate field divides pclk by 2,4,8,16
// RL3: byte end sets done flag, raises interrupt
// RL4: interrupt acknowledge clears the done flag
// RL5: writing zero clears the done flag
// RL6: data write while busy sets collision flag
// RL7: zero write or idle data write clears collision
// RL8: enabled select pin driven low sets fault
// RL9: select disable bit ignores pin, resets zero
// RL10: busy from byte load until done flag
`timescale 1ns/10ps
`default_nettype none
module spics_top
  import spics_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_ack,
  input wire logic miso,
  input wire logic ss_n,
  output logic sck,
  output logic mosi,
  output logic irq
);
  spics_stat_s stat_reg, stat_next;
  spics_state_e state_reg, state_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] rx_reg, rx_next;
  logic [2:0] div_reg, div_next;
  logic [2:0] bit_reg, bit_next;
  logic rxbit_reg, rxbit_next;
  logic sck_reg, sck_next;
  logic mosi_reg, mosi_next;
  logic [2:0] mask_reg, mask_next;
  logic [2:0] ist_reg, ist_next;
  logic irq_reg, irq_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic miso_s1, miso_s2, ss_s1, ss_s2;
  logic acc, wr_en, mapped, wr_stat, wr_data, wr_mask, wr_ist;
  logic [9:0] idx;
  logic [2:0] div_lim;
  logic ev_done, ev_write_collision_flag, ev_modf, fin;
  logic [7:0] shifted;

  // two-flop synchronisers for pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
    end else if (ce) begin
      miso_s1 <= miso;
      miso_s2 <= miso_s1;
      ss_s1 <= ss_n;
      ss_s2 <= ss_s1;
    end
  end

  // bus decode; a write takes effect when pready is seen high
  assign acc = psel & penable;
  assign idx = paddr[11:2];
  assign wr_en = acc & pready_reg & pwrite;
  assign wr_stat = wr_en & (idx == SPICS_IDX_STATUS);
  assign wr_data = wr_en & (idx == SPICS_IDX_DATA);
  assign wr_mask = wr_en & (idx == SPICS_IDX_MASK);
  assign wr_ist = wr_en & (idx == SPICS_IDX_IST);
  assign mapped = (idx == SPICS_IDX_STATUS) | (idx == SPICS_IDX_DATA) |
                  (idx == SPICS_IDX_MASK) | (idx == SPICS_IDX_IST);

  // apb answer: one wait state, data and error valid with pready
  always_comb begin
    pready_next = acc & ~pready_reg;
    pslverr_next = acc & ~pready_reg & ~mapped;
    prdata_next = prdata_reg;
    if (acc && !pready_reg) begin
      unique case (idx)
        SPICS_IDX_STATUS: prdata_next = {24'h000000, stat_reg};
        SPICS_IDX_DATA: prdata_next = {24'h000000, rx_reg};
        SPICS_IDX_MASK: prdata_next = {29'h00000000, mask_reg};
        SPICS_IDX_IST: prdata_next = {29'h00000000, ist_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  // half-period length in pclk cycles minus one
  assign div_lim = 3'((4'h1 << stat_reg.rate) - 4'h1); // RL2

  // shifted byte with the received bit entering from the far side
  assign shifted = stat_reg.bit_order_select ? {rxbit_reg, sh_reg[7:1]} : {sh_reg[6:0], rxbit_reg}; // RL1

  // next state of the shifter, flags and interrupt logic
  always_comb begin
    stat_next = stat_reg;
    state_next = state_reg;
    sh_next = sh_reg;
    rx_next = rx_reg;
    div_next = div_reg;
    bit_next = bit_reg;
    rxbit_next = rxbit_reg;
    sck_next = sck_reg;
    mask_next = mask_reg;
    ist_next = ist_reg;
    ev_done = 1'b0;
    ev_write_collision_flag = 1'b0;
    ev_modf = ~stat_reg.select_pin_disable & ~ss_s2; // RL8 RL9
    fin = 1'b0;
    // serial clock divider and bit engine
    if (state_reg == SPICS_RUN) begin
      if (div_reg == div_lim) begin // RL2
        div_next = 3'h0;
        sck_next = ~sck_reg;
        if (!sck_reg) begin
          rxbit_next = miso_s2;
        end else begin
          sh_next = shifted;
          if (bit_reg == SPICS_LAST_BIT) begin
            fin = 1'b1;
            rx_next = shifted;
            state_next = SPICS_IDLE;
            stat_next.busy = 1'b0; // RL10
            ev_done = 1'b1; // RL3
          end else begin
            bit_next = bit_reg + 3'h1;
          end
        end
      end else begin
        div_next = div_reg + 3'h1;
      end
    end
    // software writes to the status register: control fields and zero-clears
    if (wr_stat) begin
      stat_next.select_pin_disable = pwdata[SPICS_BIT_SELECT_PIN_DISABLE]; // RL9
      stat_next.bit_order_select = pwdata[SPICS_BIT_BIT_ORDER_SELECT]; // RL1
      stat_next.rate = pwdata[SPICS_BIT_RATE+1:SPICS_BIT_RATE]; // RL2
      if (!pwdata[SPICS_BIT_DONE]) begin
        stat_next.done = 1'b0; // RL5
      end
      if (!pwdata[SPICS_BIT_WRITE_COLLISION_FLAG]) begin
        stat_next.write_collision_flag = 1'b0; // RL7
      end
      if (!pwdata[SPICS_BIT_MODF]) begin
        stat_next.modf = 1'b0;
      end
    end
    if (int_ack) begin
      stat_next.done = 1'b0; // RL4
    end
    // data write: collision while busy, else load and start
    if (wr_data) begin
      if (stat_reg.busy) begin
        ev_write_collision_flag = 1'b1; // RL6
      end else begin
        stat_next.write_collision_flag = 1'b0; // RL7
        stat_next.busy = 1'b1; // RL10
        state_next = SPICS_RUN;
        sh_next = pwdata[7:0];
        div_next = 3'h0;
        bit_next = 3'h0;
        sck_next = 1'b0;
      end
    end
    // mode fault aborts any transfer in flight
    if (ev_modf) begin
      state_next = SPICS_IDLE;
      stat_next.busy = 1'b0;
      sck_next = 1'b0;
    end
    // hardware sets win over software clears
    if (ev_done) begin
      stat_next.done = 1'b1; // RL3
    end
    if (ev_write_collision_flag) begin
      stat_next.write_collision_flag = 1'b1; // RL6
    end
    if (ev_modf) begin
      stat_next.modf = 1'b1; // RL8
    end
    // sticky interrupt status, write one to clear, set wins
    if (wr_mask) begin
      mask_next = pwdata[2:0];
    end
    if (wr_ist) begin
      ist_next = ist_reg & ~pwdata[2:0];
    end
    ist_next = ist_next | {ev_modf, ev_write_collision_flag, ev_done};
    irq_next = |(ist_next & mask_next);
    mosi_next = stat_next.bit_order_select ? sh_next[0] : sh_next[7]; // RL1
  end

  // registers; ce low freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= spics_stat_s'(SPICS_STATUS_RST);
      state_reg <= SPICS_IDLE;
      sh_reg <= SPICS_DATA_RST;
      rx_reg <= SPICS_DATA_RST;
      div_reg <= 3'h0;
      bit_reg <= 3'h0;
      rxbit_reg <= 1'b0;
      sck_reg <= 1'b0;
      mosi_reg <= 1'b0;
      mask_reg <= SPICS_MASK_RST;
      ist_reg <= SPICS_IST_RST;
      irq_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else if (ce) begin
      stat_reg <= stat_next;
      state_reg <= state_next;
      sh_reg <= sh_next;
      rx_reg <= rx_next;
      div_reg <= div_next;
      bit_reg <= bit_next;
      rxbit_reg <= rxbit_next;
      sck_reg <= sck_next;
      mosi_reg <= mosi_next;
      mask_reg <= mask_next;
      ist_reg <= ist_next;
      irq_reg <= irq_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign sck = sck_reg;
  assign mosi = mosi_reg;
  assign irq = irq_reg;

  // checks next to the logic
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_order;
    (state_reg == SPICS_RUN) |-> (mosi_reg == (stat_reg.bit_order_select ? sh_reg[0] : sh_reg[7]));
  endproperty
  a_order: assert property (p_order) else $error("mosi bit order wrong"); // RL1

  property p_rate;
    (ce && state_reg == SPICS_RUN && div_reg != div_lim && !ev_modf && !wr_data)
      |=> $stable(sck_reg);
  endproperty
  a_rate: assert property (p_rate) else $error("sck toggled before divide count"); // RL2

  property p_done_set;
    (ce && fin) |=> (stat_reg.done && !stat_reg.busy && ist_reg[SPICS_IRQ_DONE]);
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set at byte end"); // RL3

  property p_ack;
    (ce && int_ack && !fin) |=> !stat_reg.done;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge did not clear done"); // RL4

  property p_wzero;
    (ce && wr_stat && !pwdata[SPICS_BIT_DONE] && !fin) |=> !stat_reg.done;
  endproperty
  a_wzero: assert property (p_wzero) else $error("zero write did not clear done"); // RL5

  property p_write_collision_flag_set;
    (ce && wr_data && stat_reg.busy)
      |=> (stat_reg.write_collision_flag && (sh_reg == $past(sh_reg) || sh_reg == $past(shifted)));
  endproperty
  a_write_collision_flag_set: assert property (p_write_collision_flag_set) else $error("collision not flagged"); // RL6

  property p_write_collision_flag_clr;
    (ce && wr_data && !stat_reg.busy && !ev_modf) |=> (!stat_reg.write_collision_flag && stat_reg.busy);
  endproperty
  a_write_collision_flag_clr: assert property (p_write_collision_flag_clr) else $error("idle load mishandled"); // RL7

  property p_modf;
    (ce && !stat_reg.select_pin_disable && !ss_s2) |=> (stat_reg.modf && !stat_reg.busy);
  endproperty
  a_modf: assert property (p_modf) else $error("mode fault not flagged"); // RL8

  property p_select_pin_disable;
    (ce && stat_reg.select_pin_disable && !stat_reg.modf && !wr_stat) |=> !stat_reg.modf;
  endproperty
  a_select_pin_disable: assert property (p_select_pin_disable) else $error("fault set while pin disabled"); // RL9

  property p_busy;
    (stat_reg.busy == (state_reg == SPICS_RUN));
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag out of step"); // RL10

  c_done: cover property (ce && fin);
  c_write_collision_flag: cover property (ce && wr_data && stat_reg.busy);
  c_modf: cover property (ce && ev_modf);
  c_lsb: cover property (ce && fin && stat_reg.bit_order_select);
endmodule
`default_nettype wire

// >>> verif/spics_peer.sv
// Purpose: serial peer that echoes a preloaded byte and captures the byte it receives
// Assumes: mode 0 clocking, sck idle low, edges seen in the pclk domain
// Notes: after eight bits the miso line shows the inverse of the last bit, as a released line
`timescale 1ns/10ps
`default_nettype none
module spics_peer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic mosi,
  input wire logic load,
  input wire logic bit_order_select,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic sck_q;
  logic [7:0] sh;
  logic [3:0] n;
  // capture on sck rise, present the next bit on sck fall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      sh <= 8'h00;
      n <= 4'h8;
      rx <= 8'h00;
      miso <= 1'b0;
    end else begin
      sck_q <= sck;
      if (load) begin
        sh <= tx;
        n <= 4'h0;
        miso <= bit_order_select ? tx[0] : tx[7];
      end else if (sck && !sck_q) begin
        rx <= bit_order_select ? {mosi, rx[7:1]} : {rx[6:0], mosi};
        n <= n + 4'h1;
      end else if (!sck && sck_q && n < 4'h8) begin
        miso <= bit_order_select ? sh[n[2:0]] : sh[3'h7 - n[2:0]];
      end else if (n >= 4'h8) begin
        miso <= ~(bit_order_select ? sh[7] : sh[0]); // released line
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Purpose: self-checking bench of the serial control and status block
// Assumes: apb master with one idle cycle between transfers
// Notes: random bytes from an lfsr with a fixed start value
`timescale 1ns/10ps
`default_nettype none
module tb;
  import spics_pkg::*;
  localparam logic [11:0] A_ST = {SPICS_IDX_STATUS, 2'h0};
  localparam logic [11:0] A_DT = {SPICS_IDX_DATA, 2'h0};
  localparam logic [11:0] A_MK = {SPICS_IDX_MASK, 2'h0};
  localparam logic [11:0] A_IS = {SPICS_IDX_IST, 2'h0};
  logic pclk, presetn, ce, psel, penable, pwrite, int_ack, ss_n, load, bit_order_select, err;
  logic pready, pslverr, miso, sck, mosi, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [7:0] tx, rx;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int hi = 0;
  spics_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_ack(int_ack), .miso(miso), .ss_n(ss_n), .sck(sck), .mosi(mosi),
    .irq(irq));
  spics_peer peer (.pclk(pclk), .presetn(presetn), .sck(sck), .mosi(mosi), .load(load),
    .bit_order_select(bit_order_select), .tx(tx), .miso(miso), .rx(rx));
  // clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // cycle count, sck high time, timeout
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    hi <= hi + int'(sck && ce); // count only edges on which the design advances
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer, result left in rd and err
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: only the bench timeout ends a hung access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(irq, 1);
  endtask
  // one byte at rate r and order l, done cleared by ack or by a status write
  task automatic xfer(input logic [1:0] r, input logic l, input logic [7:0] b, input bit ack);
    int h0;
    logic [31:0] cfg;
    cfg = {24'h0, 4'h0, 1'b1, l, r};
    apb(1'b1, A_ST, cfg);
    tx <= b;
    bit_order_select <= l;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    h0 = hi;
    apb(1'b1, A_DT, {24'h0, b});
    apb(1'b0, A_ST, 0);
    chk(rd[SPICS_BIT_BUSY], 1);
    // freeze the block mid-byte; the sck high count must not change
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    wait_irq;
    chk(hi - h0, 8 << r);
    chk(rx, b);
    apb(1'b0, A_ST, 0);
    chk(rd, cfg | 32'h80);
    if (r > 2'h1) begin
      apb(1'b0, A_DT, 0);
      chk(rd, {24'h0, b});
    end
    if (ack) begin
      int_ack <= 1'b1;
      @(posedge pclk);
      int_ack <= 1'b0;
    end else apb(1'b1, A_ST, cfg);
    apb(1'b1, A_IS, 32'h7);
    apb(1'b0, A_ST, 0);
    chk(rd, cfg);
    chk(irq, 0);
  endtask
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, int_ack, load, bit_order_select} = 7'h00;
    {ce, ss_n} = 2'h3;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx = 8'h00;
    seed = 32'h890EC8BB;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_ST, 0);
    chk(rd, 0);
    apb(1'b0, A_MK, 0);
    chk(rd, 0);
    apb(1'b0, 12'h000, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, A_MK, 32'h1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      xfer(i[1:0], i[2], seed[7:0], i == 5);
    end
    xfer(2'h3, 1'b1, 8'h01, 1'b0);
    // collision set, masked, cleared by idle write and by zero write
    apb(1'b1, A_DT, 32'hA5);
    apb(1'b1, A_DT, 32'h5A);
    apb(1'b0, A_ST, 0);
    chk(rd[SPICS_BIT_WRITE_COLLISION_FLAG], 1);
    apb(1'b0, A_IS, 0);
    chk({irq, rd[2:0]}, 4'h2);
    wait_irq;
    apb(1'b1, A_DT, 32'h33);
    apb(1'b0, A_ST, 0);
    chk(rd[SPICS_BIT_WRITE_COLLISION_FLAG], 0);
    apb(1'b1, A_DT, 32'h44);
    apb(1'b1, A_ST, 32'h0F);
    apb(1'b0, A_ST, 0);
    chk(rd[SPICS_BIT_WRITE_COLLISION_FLAG], 0);
    wait_irq;
    // mode fault with pin enabled, none with pin ignored
    apb(1'b1, A_ST, 0);
    ss_n <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, A_ST, 0);
    chk(rd[SPICS_BIT_MODF], 1);
    apb(1'b1, A_ST, 32'h08);
    apb(1'b1, A_ST, 32'h08);
    apb(1'b0, A_ST, 0);
    chk(rd, 32'h08);
    ss_n <= 1'b1;
    end_of_test();
  end
endmodule
`default_nettype wire
